// ==== hw/lcd_host_port.sv ====
// Character display controller: host strobe port, RAM pointer, memories, render tap
//
// Design decisions made here: the register addresses and the APB register port.
`timescale 1ns/100ps
module lcd_host_port
  import lcd_port_pkg::*;
#(
  parameter int CMD_CYCLES = CMD_CYC,
  parameter int DATA_CYCLES = DATA_CYC,
  parameter int CLEAR_CYCLES = CLEAR_CYC,
  parameter int BLINK_CYCLES = BLINK_CYC_DEF
) (
  input logic clk, // 100 MHz system clock
  input logic rstn, // Synchronous reset, active low
  input logic register_select, // Pin: 0 instruction, 1 data
  input logic read_write, // Pin: 1 read, 0 write
  input logic enable_strobe, // Pin: access strobe
  input logic [7:0] host_data_lines_in, // Pin data seen on the bus
  output logic [7:0] host_data_lines_out, // Data driven to the bus
  output logic [7:0] host_data_lines_oe, // High where this end drives
  input logic psel, // APB select
  input logic penable, // APB enable
  input logic pwrite, // APB direction
  input logic [11:0] paddr, // APB byte address
  input logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr // APB error
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [10:0] pin_s1_q;
  logic [10:0] pin_s2_q;
  logic en_s3_q;
  logic rs_s;
  logic rw_s;
  logic en_s;
  logic [7:0] db_s;
  logic fall;

  // Every pin goes through two flops; data and strobes share the same delay
  always_ff @(posedge clk) begin
    if (!rstn) begin
      pin_s1_q <= 11'h000;
      pin_s2_q <= 11'h000;
      en_s3_q <= 1'b0;
    end else begin
      pin_s1_q <= {register_select, read_write, enable_strobe, host_data_lines_in};
      pin_s2_q <= pin_s1_q;
      en_s3_q <= pin_s2_q[8];
    end
  end

  assign rs_s = pin_s2_q[10];
  assign rw_s = pin_s2_q[9];
  assign en_s = pin_s2_q[8];
  assign db_s = pin_s2_q[7:0];
  // Access completes on the enable fall; data still held by hold time
  assign fall = en_s3_q & ~en_s;

  // ----------------------------------------------------------------
  // Control state declarations
  // ----------------------------------------------------------------
  state_t state_q;
  logic [CNT_W-1:0] cnt_q;
  logic [6:0] sweep_q;
  logic [6:0] ptr_q;
  logic cg_q;
  logic width8_q;
  logic two_q;
  logic font10_q;
  logic inc_q;
  logic shift_q;
  logic disp_q;
  logic cur_q;
  logic blink_q;
  logic nib_q;
  logic [3:0] hi_q;
  logic busy_w;

  assign busy_w = (state_q != ST_IDLE);

  // ----------------------------------------------------------------
  // Nibble sequencing
  // ----------------------------------------------------------------
  logic byte_done;
  logic [7:0] byte_w;
  logic go;
  logic cmd_go;
  logic wr_go;
  logic rd_go;
  logic clear_cmd;

  // Phase tracks every access, even refused ones, so the host stays aligned
  always_ff @(posedge clk) begin
    if (!rstn) begin
      nib_q <= 1'b0;
      hi_q <= 4'h0;
    end else if (fall && !width8_q) begin
      if (!nib_q) begin
        hi_q <= db_s[7:4];
        nib_q <= 1'b1;
      end else begin
        nib_q <= 1'b0;
      end
    end
  end

  // 8-bit takes all lines at once; 4-bit joins high then low on lines 4..7
  assign byte_done = fall & (width8_q | nib_q);
  assign byte_w = width8_q ? db_s : {hi_q, db_s[7:4]};
  // Nothing but an instruction read is served while busy
  assign go = byte_done & ~busy_w;
  assign cmd_go = go & ~rs_s & ~rw_s;
  assign wr_go = go & rs_s & ~rw_s;
  assign rd_go = go & rs_s & rw_s;
  assign clear_cmd = cmd_go && (byte_w[7:1] == 7'h00) && byte_w[0];

  // ----------------------------------------------------------------
  // Busy sequencer
  // ----------------------------------------------------------------
  // Busy timing per command class; clear first sweeps the text memory
  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_q <= ST_IDLE;
      cnt_q <= '0;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (clear_cmd) begin
            state_q <= ST_CLEAR;
            cnt_q <= CNT_W'(CLEAR_CYCLES - 1);
          end else if (cmd_go) begin
            state_q <= ST_BUSY;
            cnt_q <= CNT_W'(CMD_CYCLES - 1);
          end else if (wr_go || rd_go) begin
            state_q <= ST_BUSY;
            cnt_q <= CNT_W'(DATA_CYCLES - 1);
          end
        end
        ST_BUSY: begin
          if (cnt_q == '0) begin
            state_q <= ST_IDLE;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        ST_CLEAR: begin
          if (cnt_q != '0) begin
            cnt_q <= cnt_q - 1'b1;
          end
          if (sweep_q == 7'(DD_DEPTH - 1)) begin
            state_q <= ST_BUSY;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Sweep index for clear; reset to zero whenever not clearing
  always_ff @(posedge clk) begin
    if (!rstn || state_q != ST_CLEAR) begin
      sweep_q <= 7'h00;
    end else begin
      sweep_q <= sweep_q + 7'h01;
    end
  end

  // ----------------------------------------------------------------
  // Instruction decode and RAM pointer
  // ----------------------------------------------------------------
  // Highest set opcode bit picks the instruction
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ptr_q <= 7'h00;
      cg_q <= 1'b0;
      width8_q <= 1'b1;
      two_q <= 1'b0;
      font10_q <= 1'b0;
      inc_q <= 1'b1;
      shift_q <= 1'b0;
      disp_q <= 1'b0;
      cur_q <= 1'b0;
      blink_q <= 1'b0;
    end else if (cmd_go) begin
      if (byte_w[OP_DDADDR]) begin
        ptr_q <= byte_w[6:0];
        cg_q <= 1'b0;
      end else if (byte_w[OP_CGADDR]) begin
        ptr_q <= {1'b0, byte_w[5:0]};
        cg_q <= 1'b1;
      end else if (byte_w[OP_FUNC]) begin
        width8_q <= byte_w[FUNC_DL];
        two_q <= byte_w[FUNC_N];
        font10_q <= byte_w[FUNC_F];
      end else if (byte_w[OP_SHIFT]) begin
        // Only cursor moves act here; the whole-display shift is not modelled
        if (!byte_w[SHIFT_SC]) begin
          ptr_q <= step_ptr(ptr_q, byte_w[SHIFT_RL], cg_q, two_q);
        end
      end else if (byte_w[OP_DISP]) begin
        disp_q <= byte_w[DISP_D];
        cur_q <= byte_w[DISP_C];
        blink_q <= byte_w[DISP_B];
      end else if (byte_w[OP_ENTRY]) begin
        inc_q <= byte_w[ENTRY_ID];
        shift_q <= byte_w[ENTRY_SH];
      end else if (byte_w[OP_HOME]) begin
        ptr_q <= 7'h00;
        cg_q <= 1'b0;
      end else if (byte_w[0]) begin
        ptr_q <= 7'h00;
        cg_q <= 1'b0;
        inc_q <= 1'b1;
      end
    end else if (wr_go || rd_go) begin
      ptr_q <= step_ptr(ptr_q, inc_q, cg_q, two_q);
    end
  end

  // ----------------------------------------------------------------
  // Text and user glyph memories
  // ----------------------------------------------------------------
  logic [7:0] dd_mem [DD_DEPTH];
  logic [7:0] cg_mem [CG_DEPTH];
  logic [6:0] dd_idx;
  logic dd_ok;

  // Pointer outside the 80 stored codes writes nothing and reads zero
  assign dd_idx = dd_index(ptr_q, two_q);
  assign dd_ok = (dd_idx < 7'(DD_DEPTH));

  // Text memory: clear sweep has priority over host data writes
  always_ff @(posedge clk) begin
    if (state_q == ST_CLEAR) begin
      dd_mem[sweep_q] <= SPACE_CODE;
    end else if (wr_go && !cg_q && dd_ok) begin
      dd_mem[dd_idx] <= byte_w;
    end
  end

  // User glyph rows, 8 glyphs of 8 rows each
  always_ff @(posedge clk) begin
    if (wr_go && cg_q) begin
      cg_mem[ptr_q[5:0]] <= byte_w;
    end
  end

  // ----------------------------------------------------------------
  // Host read path
  // ----------------------------------------------------------------
  logic [7:0] ram_rd;
  logic [7:0] rd_byte;

  assign ram_rd = cg_q ? cg_mem[ptr_q[5:0]] : (dd_ok ? dd_mem[dd_idx] : 8'h00);
  // Instruction read: busy on line 7, pointer on lines 0..6
  assign rd_byte = rs_s ? ram_rd : {busy_w, ptr_q};

  // Registered drive value; 4-bit reads send high nibble then low on 7..4
  always_ff @(posedge clk) begin
    if (!rstn) begin
      host_data_lines_out <= 8'h00;
    end else if (width8_q) begin
      host_data_lines_out <= rd_byte;
    end else begin
      host_data_lines_out <= {nib_q ? rd_byte[3:0] : rd_byte[7:4], 4'h0};
    end
  end

  // Drive only while a read strobe is high; low lines stay off in 4-bit
  assign host_data_lines_oe = (en_s && rw_s) ? (width8_q ? 8'hFF : 8'hF0) : 8'h00;

  // ----------------------------------------------------------------
  // Glyph render tap
  // ----------------------------------------------------------------
  logic [RSEL_W-1:0] rsel_q;
  logic [6:0] rpos;
  logic [2:0] rrow;
  logic [6:0] r_idx;
  logic [7:0] r_code;
  logic r_user;
  logic [4:0] r_glyph;
  logic r_here;
  logic [4:0] pix_w;
  logic [31:0] blink_cnt_q;
  logic phase_q;

  // Synthetic stand-in pattern; only the code ranges per font are decoded
  function automatic logic [4:0] rom_row(input logic [7:0] c, input logic [2:0] r);
    rom_row = 5'h00;
    if (int'(c) >= int'(ROM8_FIRST) && int'(c) < int'(ROM8_FIRST) + ROM8_COUNT) begin
      rom_row = c[4:0] ^ {2'b00, r};
    end else if (int'(c) >= int'(ROM10_FIRST) && int'(c) < int'(ROM10_FIRST) + ROM10_COUNT) begin
      rom_row = ~(c[4:0] ^ {2'b00, r});
    end
  endfunction

  assign rpos = rsel_q[6:0];
  assign rrow = rsel_q[10:8];
  assign r_idx = dd_index(rpos, two_q);
  assign r_code = (r_idx < 7'(DD_DEPTH)) ? dd_mem[r_idx] : 8'h00;
  // Upper code nibble zero means user glyph; bit 3 takes no part
  assign r_user = (r_code[7:4] == 4'h0);
  // Code bits 2..0 pick the glyph, row picks the line; bits 4..0 are dots
  assign r_glyph = r_user ? cg_mem[{r_code[2:0], rrow}][4:0] : rom_row(r_code, rrow);
  assign r_here = (rpos == ptr_q) && !cg_q;

  // Eighth row ORs the cursor; blink swaps the cell to all dots
  always_comb begin
    pix_w = r_glyph;
    if (r_here && cur_q && rrow == CURSOR_ROW) begin
      pix_w = r_glyph | ALL_DOTS;
    end
    if (r_here && blink_q && phase_q) begin
      pix_w = ALL_DOTS;
    end
    if (!disp_q) begin
      pix_w = 5'h00;
    end
  end

  // Blink phase divider
  always_ff @(posedge clk) begin
    if (!rstn) begin
      blink_cnt_q <= 32'h0000_0000;
      phase_q <= 1'b0;
    end else if (blink_cnt_q >= 32'(BLINK_CYCLES - 1)) begin
      blink_cnt_q <= 32'h0000_0000;
      phase_q <= ~phase_q;
    end else begin
      blink_cnt_q <= blink_cnt_q + 32'h0000_0001;
    end
  end

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  status_t status_w;
  logic apb_setup;
  logic apb_access;
  logic rd_ok;
  logic wr_ok;

  assign status_w = '{font10: font10_q, shift_en: shift_q, inc: inc_q, two_line: two_q,
                      blink_on: blink_q, cursor_on: cur_q, display_on: disp_q,
                      cg_sel: cg_q, width8: width8_q, busy: busy_w, ptr: ptr_q};
  assign apb_setup = psel & ~penable;
  assign apb_access = psel & penable;
  assign rd_ok = (paddr == ADDR_STATUS) || (paddr == ADDR_RSEL) || (paddr == ADDR_RPIX);
  assign wr_ok = (paddr == ADDR_RSEL);
  // Zero wait: read data is captured in the setup cycle
  assign pready = 1'b1;
  assign pslverr = apb_access & (pwrite ? ~wr_ok : ~rd_ok);

  // Read data register
  always_ff @(posedge clk) begin
    if (!rstn) begin
      prdata <= 32'h0000_0000;
    end else if (apb_setup && !pwrite) begin
      unique case (paddr)
        ADDR_STATUS: prdata <= 32'(status_w);
        ADDR_RSEL: prdata <= 32'(rsel_q);
        ADDR_RPIX: prdata <= 32'(pix_w);
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  // Render select register, the only writable location
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rsel_q <= '0;
    end else if (apb_access && pwrite && wr_ok) begin
      rsel_q <= pwdata[RSEL_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  a_busy_after_cmd: assert property (cmd_go |=> busy_w [*2])
    else $error("busy not raised after accepted instruction");
  a_first_nibble_idle: assert property (
    (fall && !width8_q && !nib_q && !busy_w) |=> !busy_w)
    else $error("busy raised after first nibble");
  a_refused_keeps_ptr: assert property ((byte_done && busy_w && !rw_s) |=> $stable(ptr_q))
    else $error("instruction accepted while busy");
  a_flag_on_db7: assert property (
    (en_s && rw_s && !rs_s && $past(en_s && rw_s && !rs_s) && width8_q && $past(width8_q))
    |-> host_data_lines_out[7] == $past(busy_w))
    else $error("line 7 does not show busy");
  a_ptr_on_low: assert property (
    (en_s && rw_s && !rs_s && $past(en_s && rw_s && !rs_s) && width8_q && $past(width8_q))
    |-> host_data_lines_out[6:0] == $past(ptr_q))
    else $error("lines 0..6 do not show the pointer");
  a_dd_addr_load: assert property ((cmd_go && byte_w[OP_DDADDR])
    |=> (ptr_q == $past(byte_w[6:0])) && !cg_q)
    else $error("text address not loaded");
  a_cg_addr_load: assert property ((cmd_go && !byte_w[OP_DDADDR] && byte_w[OP_CGADDR])
    |=> (ptr_q == {1'b0, $past(byte_w[5:0])}) && cg_q)
    else $error("glyph address not loaded");
  a_cg_ptr_step: assert property ((wr_go && cg_q && inc_q)
    |=> ptr_q[5:0] == $past(ptr_q[5:0]) + 6'h01)
    else $error("pointer did not step by one");
  a_width_select: assert property ((cmd_go && byte_w[7:5] == 3'b001)
    |=> width8_q == $past(byte_w[FUNC_DL]))
    else $error("bus width not taken from bit 4");
  a_low_lines_off: assert property (!width8_q |-> host_data_lines_oe[3:0] == 4'h0)
    else $error("low lines driven in 4-bit width");
  a_cursor_row: assert property (
    (disp_q && cur_q && r_here && rrow == CURSOR_ROW) |-> pix_w == ALL_DOTS)
    else $error("cursor row not lit");

  c_nibble_write: cover property (cmd_go && !width8_q);
  c_byte_write: cover property (wr_go && width8_q);
  c_status_read: cover property (fall && rw_s && !rs_s);
  c_clear_run: cover property (state_q == ST_CLEAR ##1 state_q == ST_BUSY);

endmodule

// ==== shared/lcd_port_pkg.sv ====
// Constants, types and shared helpers for the character display host port
package lcd_port_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 100;
  localparam int CMD_TIME_NS = 39000;
  localparam int DATA_TIME_NS = 43000;
  localparam int CLEAR_TIME_NS = 1530000;
  localparam int CMD_CYC = (CMD_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int DATA_CYC = (DATA_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int CLEAR_CYC = (CLEAR_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int BLINK_CYC_DEF = 32'h0262_5A00;
  localparam int CNT_W = 18;

  // ----------------------------------------------------------------
  // APB register map
  // ----------------------------------------------------------------
  localparam logic [11:0] ADDR_STATUS = 12'h000;
  localparam logic [11:0] ADDR_RSEL = 12'h004;
  localparam logic [11:0] ADDR_RPIX = 12'h008;
  localparam int RSEL_W = 11;

  // ----------------------------------------------------------------
  // Instruction opcode bits and fields
  // ----------------------------------------------------------------
  localparam int OP_DDADDR = 7;
  localparam int OP_CGADDR = 6;
  localparam int OP_FUNC = 5;
  localparam int OP_SHIFT = 4;
  localparam int OP_DISP = 3;
  localparam int OP_ENTRY = 2;
  localparam int OP_HOME = 1;
  localparam int FUNC_DL = 4;
  localparam int FUNC_N = 3;
  localparam int FUNC_F = 2;
  localparam int SHIFT_SC = 3;
  localparam int SHIFT_RL = 2;
  localparam int DISP_D = 2;
  localparam int DISP_C = 1;
  localparam int DISP_B = 0;
  localparam int ENTRY_ID = 1;
  localparam int ENTRY_SH = 0;

  // ----------------------------------------------------------------
  // Memory layout
  // ----------------------------------------------------------------
  localparam int DD_DEPTH = 80;
  localparam int CG_DEPTH = 64;
  localparam logic [6:0] LINE1_LAST = 7'h27;
  localparam logic [6:0] LINE2_BASE = 7'h40;
  localparam logic [6:0] LINE2_LAST = 7'h67;
  localparam logic [6:0] ONE_LINE_LAST = 7'h4F;
  localparam logic [6:0] LINE_LEN = 7'h28;
  localparam logic [7:0] SPACE_CODE = 8'h20;
  localparam logic [7:0] ROM8_FIRST = 8'h10;
  localparam logic [7:0] ROM10_FIRST = 8'hE0;
  localparam int ROM8_COUNT = 204;
  localparam int ROM10_COUNT = 32;
  localparam logic [2:0] CURSOR_ROW = 3'h7;
  localparam logic [4:0] ALL_DOTS = 5'h1F;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_BUSY = 2'b01,
    ST_CLEAR = 2'b10
  } state_t;

  typedef struct packed {
    logic font10;
    logic shift_en;
    logic inc;
    logic two_line;
    logic blink_on;
    logic cursor_on;
    logic display_on;
    logic cg_sel;
    logic width8;
    logic busy;
    logic [6:0] ptr;
  } status_t;

  // Pointer to text memory index; two-line mode packs line 2 after line 1
  function automatic logic [6:0] dd_index(input logic [6:0] p, input logic two);
    dd_index = (two && p[6]) ? {1'b0, p[5:0]} + LINE_LEN : p;
  endfunction

  // Next pointer value, wrapping within the active memory
  function automatic logic [6:0] step_ptr(input logic [6:0] p, input logic up,
                                          input logic cg, input logic two);
    if (cg) begin
      step_ptr = {1'b0, up ? p[5:0] + 6'h01 : p[5:0] - 6'h01};
    end else if (two) begin
      if (up) begin
        step_ptr = (p == LINE1_LAST) ? LINE2_BASE : (p == LINE2_LAST) ? 7'h00 : p + 7'h01;
      end else begin
        step_ptr = (p == 7'h00) ? LINE2_LAST : (p == LINE2_BASE) ? LINE1_LAST : p - 7'h01;
      end
    end else if (up) begin
      step_ptr = (p == ONE_LINE_LAST) ? 7'h00 : p + 7'h01;
    end else begin
      step_ptr = (p == 7'h00) ? ONE_LINE_LAST : p - 7'h01;
    end
  endfunction

endpackage

// ==== test/lcd_host_model.sv ====
// Host processor model that drives the strobe bus of the display port
`timescale 1ns/100ps
module lcd_host_model (
  input wire logic clk, // System clock
  output logic register_select, // Instruction or data
  output logic read_write, // Read when high
  output logic enable_strobe, // Access strobe
  output logic [7:0] host_data_lines_in, // Resolved bus level
  input wire logic [7:0] host_data_lines_out, // Device drive value
  input wire logic [7:0] host_data_lines_oe, // Device drive enable
  output logic rd_pulse, // One cycle with a checked read byte
  output logic [7:0] rd_byte // Assembled read byte
);
  logic [7:0] drv_q;
  logic wr_q;
  // Released lines show the inverse, so a stale value never passes as data
  assign host_data_lines_in = (host_data_lines_out & host_data_lines_oe) |
    ((wr_q ? drv_q : ~drv_q) & ~host_data_lines_oe);
  initial begin
    {register_select, read_write, enable_strobe, drv_q, wr_q, rd_pulse, rd_byte} = '0;
  end
  // One access; select lines held well past the fall for the synchronisers
  task automatic acc(input logic rs, input logic rw, input logic [7:0] d,
                     output logic [7:0] q);
    @(posedge clk);
    register_select <= rs;
    read_write <= rw;
    drv_q <= d;
    wr_q <= !rw;
    repeat (4) @(posedge clk);
    enable_strobe <= 1'b1;
    repeat (6) @(posedge clk);
    q = host_data_lines_in;
    enable_strobe <= 1'b0;
    repeat (4) @(posedge clk);
    wr_q <= 1'b0;
  endtask
  // Whole byte; junk on the lower lines in 4-bit width
  task automatic xfer(input logic w4, input logic rs, input logic rw,
                      input logic [7:0] d, input logic chk, output logic [7:0] q);
    logic [7:0] a;
    logic [7:0] b;
    if (w4) begin
      acc(rs, rw, {d[7:4], 4'($urandom)}, a);
      acc(rs, rw, {d[3:0], 4'($urandom)}, b);
      q = {a[7:4], b[7:4]};
    end else begin
      acc(rs, rw, d, q);
    end
    if (chk) begin
      rd_byte <= q;
      rd_pulse <= 1'b1;
      @(posedge clk);
      rd_pulse <= 1'b0;
    end
  endtask
endmodule

// ==== test/lcd_host_port_tb.sv ====
// Self-checking bench for the display host port
`timescale 1ns/100ps
module lcd_host_port_tb;
  import lcd_port_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, ap_v = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, ap_d = '0;
  logic pready, pslverr, rs, rw, en, rd_pulse;
  logic [7:0] din, dout, doe, rd_byte;
  logic [31:0] exp_q [$];
  int mismatches = 0, check_count = 0;
  always #5 clk = ~clk;
  lcd_host_port #(.CMD_CYCLES(60), .DATA_CYCLES(60), .CLEAR_CYCLES(100), .BLINK_CYCLES(16)) dut (
    .clk(clk), .rstn(rstn), .register_select(rs), .read_write(rw), .enable_strobe(en),
    .host_data_lines_in(din), .host_data_lines_out(dout), .host_data_lines_oe(doe),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));
  lcd_host_model host (.clk(clk), .register_select(rs), .read_write(rw), .enable_strobe(en),
    .host_data_lines_in(din), .host_data_lines_out(dout), .host_data_lines_oe(doe),
    .rd_pulse(rd_pulse), .rd_byte(rd_byte));
  task automatic final_report();
    if (mismatches == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic tmo();
    mismatches++;
    $display("unexpected %0t wait ran out", $time);
    final_report();
  endtask
  task automatic cmp(input logic [31:0] got);
    logic [31:0] e;
    check_count++;
    e = (exp_q.size() > 0) ? exp_q.pop_front() : 32'hxxxx_xxxx;
    if (got !== e) begin
      mismatches++;
      $display("unexpected %0t got %h want %h", $time, got, e);
    end
  endtask
  // Pin read bytes and APB results each have their own entry point
  task automatic cmp_pin(input logic [7:0] got);
    cmp({24'h0, got});
  endtask
  task automatic cmp_apb(input logic [31:0] got);
    cmp(got);
  endtask
  // Monitor: each result that appears takes the oldest expectation
  always @(posedge clk) begin
    if (rd_pulse === 1'b1) cmp_pin(rd_byte);
    if (ap_v === 1'b1) cmp_apb(ap_d);
  end
  // APB transfer; error flag reported in bit 31 of the result
  task automatic apx(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic [31:0] e);
    int n;
    exp_q.push_back(e);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (n == 50) tmo();
    ap_d <= wr ? {pslverr, 31'h0} : {pslverr, prdata[30:0]};
    ap_v <= 1'b1;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
    ap_v <= 1'b0;
  endtask
  task automatic hrd(input logic w4, input logic s, input logic [7:0] e);
    logic [7:0] q;
    exp_q.push_back({24'h0, e});
    host.xfer(w4, s, 1'b1, 8'h00, 1'b1, q);
  endtask
  task automatic hwr(input logic w4, input logic s, input logic [7:0] d);
    logic [7:0] q;
    host.xfer(w4, s, 1'b0, d, 1'b0, q);
  endtask
  // Busy poll before the next instruction, bounded
  task automatic poll(input logic w4);
    logic [7:0] q;
    int n;
    for (n = 0; n < 40; n++) begin
      host.xfer(w4, 1'b0, 1'b1, 8'h00, 1'b0, q);
      if (q[7] === 1'b0) break;
    end
    if (n == 40) tmo();
  endtask
  task automatic cmd(input logic w4, input logic [7:0] d);
    hwr(w4, 1'b0, d);
    poll(w4);
  endtask
  // Hang guard
  initial begin
    repeat (100000) @(posedge clk);
    tmo();
  end
  // Main sequence
  initial begin
    logic [7:0] r1;
    logic [7:0] q;
    logic [4:0] rows [8];
    int i;
    r1 = 8'($urandom(78642));
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    apx(0, ADDR_STATUS, 0, 32'h0000_4100);
    apx(0, 12'h00C, 0, 32'h8000_0000);
    apx(1, ADDR_STATUS, 32'h1, 32'h8000_0000);
    cmd(0, 8'h38);
    cmd(0, 8'hC0);
    hwr(0, 1, r1);
    hrd(0, 0, 8'hC1);
    hwr(0, 1, ~r1);
    poll(0);
    hrd(0, 0, 8'h41);
    cmd(0, 8'hC0);
    hrd(0, 1, r1);
    poll(0);
    cmd(0, 8'h04);
    cmd(0, 8'h80);
    hwr(0, 1, r1);
    poll(0);
    hrd(0, 0, 8'h67);
    // Clear blanks the text, homes the pointer and restores increment
    cmd(0, 8'h01);
    hrd(0, 1, 8'h20);
    poll(0);
    hrd(0, 0, 8'h01);
    cmd(0, 8'h02);
    hrd(0, 0, 8'h00);
    cmd(0, 8'h14);
    hrd(0, 0, 8'h01);
    cmd(0, 8'h06);
    cmd(0, 8'h58);
    for (i = 0; i < 8; i++) begin
      rows[i] = 5'($urandom);
      hwr(0, 1, {3'($urandom), rows[i]});
      poll(0);
    end
    cmd(0, 8'h80);
    hwr(0, 1, 8'h0B);
    poll(0);
    cmd(0, 8'h0C);
    for (i = 0; i < 8; i++) begin
      apx(1, ADDR_RSEL, {21'h0, 3'(i), 8'h00}, 32'h0);
      apx(0, ADDR_RPIX, 0, {27'h0, rows[i]});
    end
    apx(0, ADDR_RSEL, 0, 32'h0000_0700);
    cmd(0, 8'h0E);
    cmd(0, 8'h80);
    apx(0, ADDR_RPIX, 0, 32'h0000_001F);
    hwr(0, 0, 8'h28);
    poll(1);
    host.acc(0, 0, {4'hC, 4'($urandom)}, q);
    repeat (3) @(posedge clk);
    apx(0, ADDR_STATUS, 0, 32'h0000_6C00);
    host.acc(0, 0, {4'h5, 4'($urandom)}, q);
    repeat (3) @(posedge clk);
    apx(0, ADDR_STATUS, 0, 32'h0000_6CC5);
    poll(1);
    hwr(1, 1, r1);
    poll(1);
    cmd(1, 8'hC5);
    hrd(1, 1, r1);
    poll(1);
    hrd(1, 0, 8'h46);
    final_report();
  end
endmodule
